/* rtl/wdrt_consts.svh */
`ifndef WDRT_CONSTS_SVH
`define WDRT_CONSTS_SVH

`define WDRT_ADDR_W         12
`define WDRT_DATA_W         32
`define WDRT_CNT_W          18
`define WDRT_OFF_CTRL       12'h000
`define WDRT_OFF_STAT       12'h004
`define WDRT_OFF_CLR        12'h008
`define WDRT_OFF_EN         12'h00C

`define WDRT_BIT_CLEAR      0
`define WDRT_BIT_RSTEN      1
`define WDRT_BIT_RSTFLAG    2
`define WDRT_BIT_TOFLAG     3
`define WDRT_BIT_WAKEEN     4
`define WDRT_BIT_IRQEN      6
`define WDRT_BIT_CNTEN      7
`define WDRT_SEL_LO         8
`define WDRT_SEL_HI         10

`define WDRT_EV_W           3
`define WDRT_EV_TIMEOUT     0
`define WDRT_EV_CHIPRST     1
`define WDRT_EV_WAKE        2

`define WDRT_GRACE_TICKS    11'h400
`define WDRT_HOLD_TICKS     11'h03F
`define WDRT_TICK_W         11
`define WDRT_SEL_BASE       5'h04

`endif

/* rtl/wdrt_pkg.sv */
package wdrt_pkg;

    typedef struct packed {
        logic       countEn;
        logic       irqEn;
        logic       wakeEn;
        logic       resetEn;
        logic [2:0] intervalSel;
    } wdrt_ctrl_type;

    typedef struct packed {
        logic [11:0] addr;
        logic        sel;
        logic        enable;
        logic        write;
        logic [31:0] wdata;
    } wdrt_apb_req_type;

    typedef enum {
        WDRT_RUN,
        WDRT_GRACE,
        WDRT_HOLD
    } wdrt_state_type;

endpackage

/* rtl/wdrt_sync.sv */
module wdrt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule

/* rtl/wdrt_top.sv */
// Notes on behaviour
// - an 18-bit counter advancing once per guard clock cycle is the time base
// - count enable bit 7 lets the counter run; clear, it holds still
// - reaching the interval sets the timeout flag; interrupt with irq enable or with the timeout status bit enabled
// - each timeout opens a 1024 guard clock grace window where a clear saves the chip
// - writing one to bit 0 zeroes the counter; the bit reads back zero
// - bits 10:8 pick interval 2^4,2^6,...,2^18 guard clocks, codes 000 to 111
// - with bit 1 set, grace expiry without clear sets the reset flag and resets chip
// - the chip reset is held for 63 guard clock cycles, then released
// - the chip reset flag survives the reset it causes
// - in power down with wake enable bit 4, reaching the interval wakes the chip
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "wdrt_consts.svh"

module wdrt_top (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic [`WDRT_ADDR_W-1:0]  paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`WDRT_DATA_W-1:0]  pwdata,
    output logic      [`WDRT_DATA_W-1:0]  prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     guardClock,
    input  wire logic                     powerDown,
    output logic                          irq,
    output logic                          chipReset,
    output logic                          wakeup
);

    wdrt_pkg::wdrt_apb_req_type req;
    wdrt_pkg::wdrt_ctrl_type    ctrl_reg;
    wdrt_pkg::wdrt_ctrl_type    ctrl_next;
    wdrt_pkg::wdrt_state_type   state_reg;
    wdrt_pkg::wdrt_state_type   state_next;

    logic [1:0]                syncOut;
    logic                      guardSync;
    logic                      powerDownSync;
    logic                      guardPrev_reg;
    logic                      tick;

    logic [`WDRT_CNT_W-1:0]    count_reg;
    logic [`WDRT_CNT_W-1:0]    count_next;
    logic [`WDRT_TICK_W-1:0]   phase_reg;
    logic [`WDRT_TICK_W-1:0]   phase_next;
    logic                      toFlag_reg;
    logic                      toFlag_next;
    logic                      rstFlag_reg;
    logic                      rstFlag_next;
    logic [`WDRT_EV_W-1:0]     status_reg;
    logic [`WDRT_EV_W-1:0]     status_next;
    logic [`WDRT_EV_W-1:0]     evEnable_reg;
    logic [`WDRT_EV_W-1:0]     evEnable_next;
    logic                      wake_reg;
    logic                      wake_next;
    logic [`WDRT_DATA_W-1:0]   rdata_reg;
    logic [`WDRT_DATA_W-1:0]   rdata_next;

    logic                      setupPhase;
    logic                      wrAccess;
    logic                      ctrlWrite;
    logic                      clearWrite;
    logic                      intervalHit;
    logic                      graceDone;
    logic                      holdDone;
    logic                      resetFires;
    logic [`WDRT_EV_W-1:0]     events;
    logic [`WDRT_EV_W-1:0]     stsClear;
    logic                      clrWrite;
    logic                      enWrite;

    // true on the guard tick that closes a window of the given length
    function automatic logic window_end(input logic [`WDRT_TICK_W-1:0] ph,
                                        input logic [`WDRT_TICK_W-1:0] len);
        window_end = (ph == len - `WDRT_TICK_W'(1));
    endfunction

    // one-hot mask of the selected interval minus one
    function automatic logic [`WDRT_CNT_W-1:0] interval_mask(input logic [2:0] sel);
        logic [4:0] shift;
        shift = `WDRT_SEL_BASE + {1'b0, sel, 1'b0};
        interval_mask = `WDRT_CNT_W'((19'h00001 << shift) - 19'h00001);
    endfunction

    // address decode shared by the write path and pslverr; the read path has its own case
    function automatic logic addr_mapped(input logic [`WDRT_ADDR_W-1:0] a);
        addr_mapped = (a == `WDRT_OFF_CTRL) || (a == `WDRT_OFF_STAT) ||
                      (a == `WDRT_OFF_CLR) || (a == `WDRT_OFF_EN);
    endfunction

    assign req = '{addr: paddr, sel: psel, enable: penable, write: pwrite, wdata: pwdata};

    // guard clock and power down come from outside the domain
    wdrt_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst    (rst),
        .asyncIn({powerDown, guardClock}),
        .syncOut(syncOut)
    );

    assign guardSync     = syncOut[0];
    assign powerDownSync = syncOut[1];
    assign tick          = guardSync & ~guardPrev_reg;

    assign setupPhase = req.sel & ~req.enable;
    assign wrAccess   = req.sel & req.enable & req.write & addr_mapped(req.addr);
    assign ctrlWrite  = wrAccess && (req.addr == `WDRT_OFF_CTRL);
    assign clearWrite = ctrlWrite & req.wdata[`WDRT_BIT_CLEAR];
    assign clrWrite   = wrAccess && (req.addr == `WDRT_OFF_CLR);
    assign enWrite    = wrAccess && (req.addr == `WDRT_OFF_EN);
    assign stsClear   = clrWrite ? req.wdata[`WDRT_EV_W-1:0] : '0;

    assign intervalHit = tick & ctrl_reg.countEn &
                         (count_reg == interval_mask(ctrl_reg.intervalSel));
    assign graceDone   = tick && (state_reg == wdrt_pkg::WDRT_GRACE) &&
                         window_end(phase_reg, `WDRT_GRACE_TICKS);
    assign holdDone    = tick && (state_reg == wdrt_pkg::WDRT_HOLD) &&
                         window_end(phase_reg, `WDRT_HOLD_TICKS);
    assign resetFires  = graceDone & ~clearWrite & ctrl_reg.resetEn;

    // counter, grace window and reset hold
    always_comb begin
        count_next = count_reg;
        phase_next = phase_reg;
        state_next = state_reg;
        if (tick && ctrl_reg.countEn) begin
            count_next = count_reg + `WDRT_CNT_W'(1);
        end
        if (tick && (state_reg != wdrt_pkg::WDRT_RUN)) begin
            phase_next = phase_reg + `WDRT_TICK_W'(1);
        end
        case (state_reg)
            wdrt_pkg::WDRT_RUN: begin
                if (intervalHit && !clearWrite) begin
                    state_next = wdrt_pkg::WDRT_GRACE;
                    phase_next = '0;
                end
            end
            wdrt_pkg::WDRT_GRACE: begin
                if (clearWrite) begin
                    state_next = wdrt_pkg::WDRT_RUN;
                end else if (resetFires) begin
                    state_next = wdrt_pkg::WDRT_HOLD;
                    phase_next = '0;
                end else if (graceDone) begin
                    state_next = wdrt_pkg::WDRT_RUN;
                end
            end
            wdrt_pkg::WDRT_HOLD: begin
                if (holdDone) begin
                    state_next = wdrt_pkg::WDRT_RUN;
                    count_next = '0;
                end
            end
            default: begin
                state_next = wdrt_pkg::WDRT_RUN;
            end
        endcase
        if (clearWrite) begin
            count_next = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg     <= '0;
            phase_reg     <= '0;
            state_reg     <= wdrt_pkg::WDRT_RUN;
            guardPrev_reg <= 1'b0;
        end else begin
            count_reg     <= count_next;
            phase_reg     <= phase_next;
            state_reg     <= state_next;
            guardPrev_reg <= guardSync;
        end
    end

    assign chipReset = (state_reg == wdrt_pkg::WDRT_HOLD);

    // control register, flags, wake-up and interrupt status
    always_comb begin
        ctrl_next     = ctrl_reg;
        toFlag_next   = toFlag_reg;
        rstFlag_next  = rstFlag_reg;
        evEnable_next = evEnable_reg;
        wake_next     = 1'b0;
        events        = '0;
        if (ctrlWrite) begin
            ctrl_next.countEn     = req.wdata[`WDRT_BIT_CNTEN];
            ctrl_next.irqEn       = req.wdata[`WDRT_BIT_IRQEN];
            ctrl_next.wakeEn      = req.wdata[`WDRT_BIT_WAKEEN];
            ctrl_next.resetEn     = req.wdata[`WDRT_BIT_RSTEN];
            ctrl_next.intervalSel = req.wdata[`WDRT_SEL_HI:`WDRT_SEL_LO];
            if (req.wdata[`WDRT_BIT_TOFLAG]) begin
                toFlag_next = 1'b0;
            end
            if (req.wdata[`WDRT_BIT_RSTFLAG]) begin
                rstFlag_next = 1'b0;
            end
        end
        if (enWrite) begin
            evEnable_next = req.wdata[`WDRT_EV_W-1:0];
        end
        if (intervalHit) begin
            toFlag_next = 1'b1;
            events[`WDRT_EV_TIMEOUT] = 1'b1;
        end
        if (intervalHit && ctrl_reg.wakeEn && powerDownSync) begin
            wake_next = 1'b1;
            events[`WDRT_EV_WAKE] = 1'b1;
        end
        if (resetFires) begin
            rstFlag_next = 1'b1;
            events[`WDRT_EV_CHIPRST] = 1'b1;
        end
        if (holdDone) begin
            // the chip reset returns control to defaults but keeps the reset flag
            ctrl_next   = '0;
            toFlag_next = 1'b0;
        end
    end

    // sticky status bits; an event wins over a clear in the same cycle
    generate
        for (genvar i = 0; i < `WDRT_EV_W; i++) begin : g_status
            always_comb begin
                status_next[i] = status_reg[i];
                if (stsClear[i]) begin
                    status_next[i] = 1'b0;
                end
                if (events[i]) begin
                    status_next[i] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg     <= '0;
            toFlag_reg   <= 1'b0;
            rstFlag_reg  <= 1'b0;
            status_reg   <= '0;
            evEnable_reg <= '0;
            wake_reg     <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            toFlag_reg   <= toFlag_next;
            rstFlag_reg  <= rstFlag_next;
            status_reg   <= status_next;
            evEnable_reg <= evEnable_next;
            wake_reg     <= wake_next;
        end
    end

    assign wakeup = wake_reg;
    assign irq    = (|(status_reg & evEnable_reg)) | (toFlag_reg & ctrl_reg.irqEn);

    // read data captured in the setup phase
    always_comb begin
        rdata_next = rdata_reg;
        if (setupPhase) begin
            rdata_next = '0;
            case (req.addr)
                `WDRT_OFF_CTRL: begin
                    rdata_next[`WDRT_BIT_CNTEN]              = ctrl_reg.countEn;
                    rdata_next[`WDRT_BIT_IRQEN]              = ctrl_reg.irqEn;
                    rdata_next[`WDRT_BIT_WAKEEN]             = ctrl_reg.wakeEn;
                    rdata_next[`WDRT_BIT_RSTEN]              = ctrl_reg.resetEn;
                    rdata_next[`WDRT_BIT_TOFLAG]             = toFlag_reg;
                    rdata_next[`WDRT_BIT_RSTFLAG]            = rstFlag_reg;
                    rdata_next[`WDRT_SEL_HI:`WDRT_SEL_LO]    = ctrl_reg.intervalSel;
                end
                `WDRT_OFF_STAT: begin
                    rdata_next[`WDRT_EV_W-1:0] = status_reg;
                end
                `WDRT_OFF_EN: begin
                    rdata_next[`WDRT_EV_W-1:0] = evEnable_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pready  = 1'b1;
    assign pslverr = req.sel & req.enable & ~addr_mapped(req.addr);

endmodule

/* tb/wdrt_top_monitor.sv */
module wdrt_top_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        powerDown,
    input wire logic        irq,
    input wire logic        chipReset,
    input wire logic        wakeup
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_acc; psel && penable; endsequence
    sequence s_hold; ##300 chipReset ##[1:200] !chipReset; endsequence
    property p_ready; s_acc |-> pready; endproperty
    property p_slverr; psel && penable && paddr > 12'h00C |-> pslverr && prdata == 32'h0; endproperty
    property p_rstout; $fell(rst) |-> !irq && !chipReset && !wakeup; endproperty
    property p_hold; $rose(chipReset) |-> s_hold; endproperty
    property p_gap; $fell(chipReset) |-> (!chipReset) [*8]; endproperty
    property p_wpulse; wakeup |=> !wakeup; endproperty
    property p_wcause; wakeup |-> $past(powerDown, 3); endproperty
    property p_irqfall; $fell(irq) |-> $past(psel && penable && pwrite) || chipReset || $past(chipReset); endproperty
    property p_nosave; $rose(chipReset) |-> !$past(psel && penable && pwrite && paddr == 12'h000 && pwdata[0]); endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    a_rstout: assert property (p_rstout) else $error("output high after reset");
    a_hold: assert property (p_hold) else $error("chip reset hold length wrong");
    a_gap: assert property (p_gap) else $error("chip reset refired at once");
    a_wpulse: assert property (p_wpulse) else $error("wakeup longer than one cycle");
    a_wcause: assert property (p_wcause) else $error("wakeup without power down");
    a_irqfall: assert property (p_irqfall) else $error("irq dropped without a write");
    a_nosave: assert property (p_nosave) else $error("chip reset right after a clear");
endmodule

bind wdrt_top wdrt_top_monitor mon_u (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .powerDown, .irq, .chipReset, .wakeup);

/* tb/watchdog_reset_wakeup_timer_test.sv */
module watchdog_reset_wakeup_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0;
    logic        rst = 1;
    logic [11:0] paddr = '0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [31:0] pwdata = '0;
    logic        guardClock = 0;
    logic        powerDown = 0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        chipReset;
    logic        wakeup;
    logic [31:0] rdata;
    logic [31:0] rnd;
    int          failures = 0;
    int          n_checks = 0;
    int          ticks = 0;
    int          phase = 0;
    int          cyc = 0;
    int          wakes = 0;
    int          base = 0;
    int          w0;
    int          selQ[$] = {0, 1, 2, 3, 4};

    wdrt_top dut_u (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .guardClock, .powerDown, .irq, .chipReset, .wakeup);

    always #25 clk_sys = ~clk_sys;

    // guard clock: 3 high, 3 low; ticks counts its rising edges
    always @(posedge clk_sys) begin
        phase <= (phase == 5) ? 0 : phase + 1;
        guardClock <= phase < 3;
        ticks <= ticks + (phase == 0);
        wakes <= wakes + wakeup;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdata = prdata;
        chk(pslverr, a > 12'h00C);
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 0, 0);
        chk(rdata, exp);
    endtask

    // control write placed between guard ticks; tick k follows when ticks == base + k
    task automatic syncWr(input logic [31:0] d);
        do @(posedge clk_sys); while (phase != 3);
        apb(12'h000, 1, d);
        base = ticks;
    endtask

    task automatic waitT(input int k);
        do @(posedge clk_sys); while (ticks != base + k);
        repeat (4) @(posedge clk_sys);
    endtask

    initial begin
        void'($urandom(67));
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        rdc(12'h000, 0);
        rdc(12'h004, 0);
        rdc(12'h00C, 0);
        rdc(12'h010, 0);
        rnd = $urandom;
        apb(12'h00C, 1, rnd);
        rdc(12'h00C, rnd & 32'h7);
        apb(12'h00C, 1, 0);
        syncWr(32'h41);
        waitT(40);
        chk(irq, 0);
        foreach (selQ[i]) begin
            syncWr((selQ[i] << 8) | 32'hC1);
            waitT((1 << (4 + 2 * selQ[i])) - 1);
            chk(irq, 0);
            waitT(1 << (4 + 2 * selQ[i]));
            chk(irq, 1);
            rdc(12'h000, (selQ[i] << 8) | 32'hC8);
            apb(12'h000, 1, 32'h48);
            chk(irq, 0);
        end
        for (int s = 5; s < 8; s++) begin
            apb(12'h000, 1, s << 8);
            rdc(12'h000, s << 8);
        end
        apb(12'h008, 1, 7);
        apb(12'h00C, 1, 1);
        syncWr(32'h81);
        waitT(16);
        chk(irq, 1);
        apb(12'h000, 1, 32'h08);
        chk(irq, 1);
        apb(12'h00C, 1, 0);
        chk(irq, 0);
        rdc(12'h004, 1);
        apb(12'h008, 1, 1);
        rdc(12'h004, 0);
        syncWr(32'h83);
        waitT(500);
        syncWr(32'h83);
        waitT(1030);
        chk(chipReset, 0);
        waitT(1039);
        chk(chipReset, 0);
        waitT(1040);
        chk(chipReset, 1);
        waitT(1102);
        chk(chipReset, 1);
        waitT(1103);
        chk(chipReset, 0);
        rdc(12'h000, 32'h4);
        rdc(12'h004, 32'h3);
        powerDown <= 1;
        w0 = wakes;
        syncWr(32'h91);
        waitT(15);
        chk(wakes - w0, 0);
        waitT(17);
        chk(wakes - w0, 1);
        rdc(12'h004, 32'h7);
        powerDown <= 0;
        rst <= 1;
        @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        rdc(12'h000, 0);
        conclude();
    end
endmodule
